// file: verilog/sensor_serial_register_port.sv
// Two-wire and SPI slave front ends sharing one register access port
//
// Functional notes
// - Two-wire slave answers only to fixed 7-bit address 1D hex.
// - No high-speed mode, 10-bit addressing, general call or START byte.
// - Single read: address+W, register, repeated start, address+R, one byte.
// - Returned data bytes go out most significant bit first.
// - Read pointer increments after each master-acknowledged byte until NAK.
// - Single write: address+W, register, data, STOP; every byte acknowledged.
// - Write pointer increments after each acknowledged data byte.
// - SPI data changes on falling clock edge, sampled on rising edge.
// - SPI single access is 16 clocks, longer ones add groups of 8.
// - SPI command MSB first: direction, 6-bit address, one don't-care bit.
// - Direction 0 reads, 1 writes; write command is followed by data.
// - After SPI read command the next byte returns register contents.
// - Three-wire mode returns read data on the shared data line.
// - Chip select low selects SPI, high selects two-wire operation.
`timescale 1ns/1ps
module sensor_serial_register_port
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// Serial pins
	input  wire logic       serialPortClock,
	input  wire logic       serialInLine,
	output logic            serialInLineOut,
	output logic            serialInLineOe_n,
	output logic            serialOutLine,
	input  wire logic       chipSelect_n,
	// Mode bits held by the register file
	input  wire logic       spiThreeWire,
	input  wire logic       twoWireDisable,
	// Register file access
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrite,
	input  wire logic [7:0] regRdData
);

	logic [serial_port_pkg::SYNC_W-1:0] syncLevel;
	logic                               sclPrev;
	logic                               sdaPrev;
	logic                               sclRise;
	logic                               sclFall;
	logic                               sdaRise;
	logic                               sdaFall;
	logic                               spiSel;
	logic                               i2cOn;
	logic                               sclNow;
	logic                               sdaNow;

	pin_sync #(.WIDTH(serial_port_pkg::SYNC_W)) u_sync
	(
		.clock   (clock),
		.rst_n   (rst_n),
		.pinIn   ({chipSelect_n, serialInLine, serialPortClock}),
		.syncOut (syncLevel)
	);

	assign sclNow  = syncLevel[serial_port_pkg::SYNC_SCL];
	assign sdaNow  = syncLevel[serial_port_pkg::SYNC_SDA];
	assign spiSel  = !syncLevel[serial_port_pkg::SYNC_CS];
	assign i2cOn   = !spiSel && !twoWireDisable;
	assign sclRise = sclNow && !sclPrev;
	assign sclFall = !sclNow && sclPrev;
	assign sdaRise = sdaNow && !sdaPrev;
	assign sdaFall = !sdaNow && sdaPrev;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end
		else
		begin
			sclPrev <= sclNow;
			sdaPrev <= sdaNow;
		end
	end

	// Two-wire slave
	serial_port_pkg::i2c_state_t i2cState;
	logic [3:0]                  i2cBits;
	logic [7:0]                  i2cShift;
	logic [7:0]                  i2cTx;
	logic                        i2cRead;
	logic                        i2cPull;
	logic [7:0]                  i2cPtr;
	logic [7:0]                  i2cWrData;
	logic                        i2cWrite;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			i2cState  <= serial_port_pkg::I2C_IDLE;
			i2cBits   <= 4'h0;
			i2cShift  <= serial_port_pkg::DATA_RESET;
			i2cTx     <= serial_port_pkg::DATA_RESET;
			i2cRead   <= 1'b0;
			i2cPull   <= 1'b0;
			i2cPtr    <= serial_port_pkg::ADDR_RESET;
			i2cWrData <= serial_port_pkg::DATA_RESET;
			i2cWrite  <= 1'b0;
		end
		else
		begin
			i2cWrite <= 1'b0;
			if (!i2cOn)
			begin
				i2cState <= serial_port_pkg::I2C_IDLE;
				i2cPull  <= 1'b0;
			end
			// Clock must already be high: our own data change can land with its rise
			else if (sclNow && sclPrev && sdaFall)
			begin
				// Start or repeated start restarts framing from any state
				i2cState <= serial_port_pkg::I2C_ADDR;
				i2cBits  <= 4'h0;
				i2cPull  <= 1'b0;
			end
			else if (sclNow && sclPrev && sdaRise)
			begin
				i2cState <= serial_port_pkg::I2C_IDLE;
				i2cPull  <= 1'b0;
			end
			else if (sclRise)
			begin
				if (i2cState == serial_port_pkg::I2C_RACK)
				begin
					if (!sdaNow)
						i2cPtr <= i2cPtr + serial_port_pkg::ADDR_STEP;
					else
						i2cState <= serial_port_pkg::I2C_IDLE;
				end
				else if (i2cBits != serial_port_pkg::I2C_BYTE_END)
				begin
					i2cShift <= {i2cShift[6:0], sdaNow};
					i2cBits  <= i2cBits + 4'h1;
				end
			end
			else if (sclFall)
			begin
				unique case (i2cState)
					serial_port_pkg::I2C_IDLE:
						i2cPull <= 1'b0;
					serial_port_pkg::I2C_ADDR:
						if (i2cBits == serial_port_pkg::I2C_BYTE_END)
						begin
							// General call and 10-bit headers never match here
							if (i2cShift[7:1] == serial_port_pkg::SLAVE_ADDR)
							begin
								i2cRead  <= i2cShift[0];
								i2cPull  <= 1'b1;
								i2cState <= serial_port_pkg::I2C_ADDR_ACK;
							end
							else
								i2cState <= serial_port_pkg::I2C_IDLE;
						end
					serial_port_pkg::I2C_ADDR_ACK:
					begin
						i2cBits <= 4'h0;
						if (i2cRead)
						begin
							// Pointer was set earlier, so read data is settled
							i2cTx    <= {regRdData[6:0], 1'b0};
							i2cPull  <= !regRdData[7];
							i2cState <= serial_port_pkg::I2C_RDATA;
						end
						else
						begin
							i2cPull  <= 1'b0;
							i2cState <= serial_port_pkg::I2C_REG;
						end
					end
					serial_port_pkg::I2C_REG:
						if (i2cBits == serial_port_pkg::I2C_BYTE_END)
						begin
							i2cPtr   <= i2cShift;
							i2cPull  <= 1'b1;
							i2cState <= serial_port_pkg::I2C_REG_ACK;
						end
					serial_port_pkg::I2C_REG_ACK,
					serial_port_pkg::I2C_WACK:
					begin
						i2cPull  <= 1'b0;
						i2cBits  <= 4'h0;
						i2cState <= serial_port_pkg::I2C_WDATA;
						// Write pointer steps once the data byte has been acknowledged
						if (i2cState == serial_port_pkg::I2C_WACK)
							i2cPtr <= i2cPtr + serial_port_pkg::ADDR_STEP;
					end
					serial_port_pkg::I2C_WDATA:
						if (i2cBits == serial_port_pkg::I2C_BYTE_END)
						begin
							i2cWrData <= i2cShift;
							i2cWrite  <= 1'b1;
							i2cPull   <= 1'b1;
							i2cState  <= serial_port_pkg::I2C_WACK;
						end
					serial_port_pkg::I2C_RDATA:
						if (i2cBits == serial_port_pkg::I2C_BYTE_END)
						begin
							i2cPull  <= 1'b0;
							i2cState <= serial_port_pkg::I2C_RACK;
						end
						else
						begin
							i2cPull <= !i2cTx[7];
							i2cTx   <= {i2cTx[6:0], 1'b0};
						end
					serial_port_pkg::I2C_RACK:
					begin
						i2cBits  <= 4'h0;
						i2cTx    <= {regRdData[6:0], 1'b0};
						i2cPull  <= !regRdData[7];
						i2cState <= serial_port_pkg::I2C_RDATA;
					end
				endcase
			end
		end
	end

	// SPI slave
	logic [2:0] spiBits;
	logic [6:0] spiShift;
	logic       spiCmdDone;
	logic       spiReadPhase;
	logic [7:0] spiTx;
	logic       spiBit;
	logic       spiDrive;
	logic [7:0] spiPtr;
	logic [7:0] spiWrData;
	logic       spiWrite;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			spiBits      <= 3'h0;
			spiShift     <= 7'h00;
			spiCmdDone   <= 1'b0;
			spiReadPhase <= 1'b0;
			spiTx        <= serial_port_pkg::DATA_RESET;
			spiBit       <= 1'b0;
			spiDrive     <= 1'b0;
			spiPtr       <= serial_port_pkg::ADDR_RESET;
			spiWrData    <= serial_port_pkg::DATA_RESET;
			spiWrite     <= 1'b0;
		end
		else
		begin
			spiWrite <= 1'b0;
			// Step only after the write has gone out on the old address
			if (spiWrite)
				spiPtr <= spiPtr + serial_port_pkg::ADDR_STEP;
			if (!spiSel)
			begin
				spiBits      <= 3'h0;
				spiCmdDone   <= 1'b0;
				spiReadPhase <= 1'b0;
				spiDrive     <= 1'b0;
			end
			else if (sclRise)
			begin
				spiShift <= {spiShift[5:0], sdaNow};
				spiBits  <= spiBits + 3'h1;
				if (spiBits == serial_port_pkg::SPI_LAST_BIT)
				begin
					if (!spiCmdDone)
					begin
						spiCmdDone   <= 1'b1;
						spiPtr       <= {2'b00, spiShift[5:0]};
						spiReadPhase <= !spiShift[6];
					end
					else if (spiReadPhase)
						spiPtr <= spiPtr + serial_port_pkg::ADDR_STEP;
					else
					begin
						spiWrData <= {spiShift, sdaNow};
						spiWrite  <= 1'b1;
					end
				end
			end
			else if (sclFall && spiReadPhase)
			begin
				spiDrive <= 1'b1;
				if (spiBits == 3'h0)
				begin
					spiBit <= regRdData[7];
					spiTx  <= {regRdData[6:0], 1'b0};
				end
				else
				begin
					spiBit <= spiTx[7];
					spiTx  <= {spiTx[6:0], 1'b0};
				end
			end
		end
	end

	// Pin and register port outputs, muxed by interface selection
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			serialInLineOut  <= 1'b0;
			serialInLineOe_n <= 1'b1;
			serialOutLine    <= 1'b0;
			regAddr          <= serial_port_pkg::ADDR_RESET;
			regWrData        <= serial_port_pkg::DATA_RESET;
			regWrite         <= 1'b0;
		end
		else if (spiSel)
		begin
			serialInLineOut  <= spiBit;
			serialInLineOe_n <= !(spiDrive && spiThreeWire);
			serialOutLine    <= spiBit;
			regAddr          <= spiPtr;
			regWrData        <= spiWrData;
			regWrite         <= spiWrite;
		end
		else
		begin
			// Open drain: only ever pull low
			serialInLineOut  <= 1'b0;
			serialInLineOe_n <= !i2cPull;
			serialOutLine    <= 1'b0;
			regAddr          <= i2cPtr;
			regWrData        <= i2cWrData;
			regWrite         <= i2cWrite;
		end
	end

endmodule

// file: verilog/serial_port_pkg.sv
// Shared constants and types for the serial register port
package serial_port_pkg;

	localparam int          BYTE_W       = 8;
	localparam logic [6:0]  SLAVE_ADDR   = 7'h1d;
	localparam logic [3:0]  I2C_BYTE_END = 4'h8;
	localparam logic [2:0]  SPI_LAST_BIT = 3'h7;
	localparam logic [7:0]  ADDR_RESET   = 8'h00;
	localparam logic [7:0]  ADDR_STEP    = 8'h01;
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	localparam int          SYNC_W       = 3;
	localparam int          SYNC_SCL     = 0;
	localparam int          SYNC_SDA     = 1;
	localparam int          SYNC_CS      = 2;

	typedef enum logic [3:0]
	{
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_REG,
		I2C_REG_ACK,
		I2C_WDATA,
		I2C_WACK,
		I2C_RDATA,
		I2C_RACK
	} i2c_state_t;

endpackage

// file: verilog/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// Pins and synchronised levels
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			logic firstStage;
			// Idle-high lines, so reset to one avoids false edges at release
			always_ff @(posedge clock or negedge rst_n)
			begin
				if (!rst_n)
				begin
					firstStage <= 1'b1;
					syncOut[i] <= 1'b1;
				end
				else
				begin
					firstStage <= pinIn[i];
					syncOut[i] <= firstStage;
				end
			end
		end
	endgenerate

endmodule

// file: verif/sensor_serial_register_port_chk.sv
// Pin-level assertions for the serial register port
`timescale 1ns/1ps
module sensor_serial_register_port_chk
(
	// Clock and reset
	input wire logic       clock,
	input wire logic       rst_n,
	// Serial pins
	input wire logic       serialPortClock,
	input wire logic       serialInLine,
	input wire logic       serialInLineOut,
	input wire logic       serialInLineOe_n,
	input wire logic       serialOutLine,
	input wire logic       chipSelect_n,
	// Mode bits and register port
	input wire logic       spiThreeWire,
	input wire logic       twoWireDisable,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrite,
	input wire logic [7:0] regRdData
);
	logic [7:0] rises;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Raw pin edges; the design lags by its synchroniser
	always_ff @(posedge clock or negedge rst_n)
		if (!rst_n)
			rises <= 8'h00;
		else if (chipSelect_n)
			rises <= 8'h00;
		else if ($rose(serialPortClock))
			rises <= rises + 8'h01;
	sequence spiRise;
		$rose(serialPortClock) && !chipSelect_n;
	endsequence
	sequence sclRise;
		$rose(serialPortClock) && chipSelect_n;
	endsequence
	sequence busOff;
		(chipSelect_n && twoWireDisable) [*6];
	endsequence
	sequence fourWire;
		(!chipSelect_n && !spiThreeWire) [*6];
	endsequence
	rst_val_a: assert property ($rose(rst_n) |-> serialInLineOe_n && !regWrite
		&& regAddr == 8'h00) else $error("outputs not idle after reset");
	wr_spacing_a: assert property (regWrite |=> !regWrite [*8])
		else $error("register writes closer than one byte");
	spi_count_a: assert property (regWrite && !chipSelect_n |->
		rises >= 8'h10 && rises[2:0] == 3'h0) else $error("write off a byte boundary");
	iic_low_a: assert property (chipSelect_n [*6] |-> serialInLineOe_n || !serialInLineOut)
		else $error("data line driven high in two-wire mode");
	four_wire_a: assert property (fourWire |-> serialInLineOe_n)
		else $error("data line driven in four-wire mode");
	bus_off_a: assert property (busOff |-> serialInLineOe_n && !regWrite)
		else $error("disabled two-wire slave active");
	spi_hold_a: assert property (spiRise |=> $stable(serialOutLine) [*5])
		else $error("data out changed near rising clock");
	iic_hold_a: assert property (sclRise |=> $stable(serialInLineOe_n) [*3])
		else $error("data line changed while clock high");
endmodule
bind sensor_serial_register_port sensor_serial_register_port_chk i_chk
(
	.clock(clock), .rst_n(rst_n), .serialPortClock(serialPortClock),
	.serialInLine(serialInLine), .serialInLineOut(serialInLineOut),
	.serialInLineOe_n(serialInLineOe_n), .serialOutLine(serialOutLine),
	.chipSelect_n(chipSelect_n), .spiThreeWire(spiThreeWire),
	.twoWireDisable(twoWireDisable), .regAddr(regAddr), .regWrData(regWrData),
	.regWrite(regWrite), .regRdData(regRdData)
);

// file: verif/mcu_master.sv
// Bus master model for both serial front ends
`timescale 1ns/1ps
module mcu_master
(
	// Clock
	input  wire logic clock,
	// Serial pins
	output logic      scl,
	output logic      csN,
	output logic      sdaDrv,
	input  wire logic sda,
	input  wire logic serial_out_line
);
	initial
	begin
		scl = 1'b1;
		csN = 1'b1;
		sdaDrv = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic iBit(input logic b, output logic r);
		sdaDrv = b;
		w(2);
		scl = 1'b1;
		w(2);
		r = sda;
		w(2);
		scl = 1'b0;
		w(2);
	endtask
	task automatic iByte(input logic [7:0] b, input logic ack,
		output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--)
			iBit(b[i], r[i]);
		iBit(ack, a);
	endtask
	// Long low phase lets the slave drop its ack before the clock rises
	task automatic iStart();
		sdaDrv = 1'b1;
		w(4);
		scl = 1'b1;
		w(4);
		sdaDrv = 1'b0;
		w(4);
		scl = 1'b0;
		w(2);
	endtask
	task automatic iStop();
		sdaDrv = 1'b0;
		w(4);
		scl = 1'b1;
		w(4);
		sdaDrv = 1'b1;
		w(4);
	endtask
	task automatic sOpen();
		csN = 1'b0;
		w(4);
	endtask
	task automatic sClose();
		sdaDrv = 1'b1;
		w(4);
		csN = 1'b1;
		w(8);
	endtask
	task automatic sXfer(input logic [7:0] tx, input int nb, input logic on3,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nb; i--)
		begin
			scl = 1'b0;
			sdaDrv = tx[i];
			w(4);
			scl = 1'b1;
			w(2);
			rx[i] = on3 ? sda : serial_out_line;
			w(2);
		end
	endtask
endmodule

// file: verif/tb_sensor_serial_register_port.sv
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module tb_sensor_serial_register_port;
	typedef struct packed
	{
		logic [1:0] kind;
		logic       three;
		logic [5:0] ra;
		logic [7:0] d;
	} row_t;
	localparam logic [6:0] DEV = serial_port_pkg::SLAVE_ADDR;
	logic       clock;
	logic       rst_n;
	logic       spiThreeWire;
	logic       twoWireDisable;
	logic [7:0] regRdData;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic       regWrite;
	logic       serialInLineOut;
	logic       serialInLineOe_n;
	logic       serialOutLine;
	logic       scl;
	logic       csN;
	logic       sdaDrv;
	wire        sda = sdaDrv & (serialInLineOe_n | serialInLineOut);
	logic [7:0] mem [64];
	logic [7:0] shadow [64];
	logic [7:0] x;
	int         fails;
	int         compares;
	logic [6:0] bad [3] = '{7'h1c, 7'h00, 7'h78};
	// Kind 0/1 two-wire write/read, 2/3 SPI write/read
	row_t       rows [10] = '{'{2'h0, 1'b0, 6'h10, 8'ha5}, '{2'h1, 1'b0, 6'h10, 8'ha5},
		'{2'h2, 1'b0, 6'h21, 8'h3c}, '{2'h3, 1'b0, 6'h21, 8'h3c}, '{2'h3, 1'b1, 6'h21, 8'h3c},
		'{2'h1, 1'b0, 6'h21, 8'h3c}, '{2'h3, 1'b0, 6'h10, 8'ha5}, '{2'h2, 1'b1, 6'h3f, 8'h81},
		'{2'h3, 1'b1, 6'h3f, 8'h81}, '{2'h1, 1'b0, 6'h3f, 8'h81}};
	sensor_serial_register_port i_dut
	(
		.clock(clock), .rst_n(rst_n), .serialPortClock(scl), .serialInLine(sda),
		.serialInLineOut(serialInLineOut), .serialInLineOe_n(serialInLineOe_n),
		.serialOutLine(serialOutLine), .chipSelect_n(csN), .spiThreeWire(spiThreeWire),
		.twoWireDisable(twoWireDisable), .regAddr(regAddr), .regWrData(regWrData),
		.regWrite(regWrite), .regRdData(regRdData)
	);
	mcu_master i_mst
	(
		.clock(clock), .scl(scl), .csN(csN), .sdaDrv(sdaDrv), .sda(sda), .serial_out_line(serialOutLine)
	);
	always #50 clock = ~clock;
	always @(posedge clock)
		if (regWrite)
			mem[regAddr[5:0]] <= regWrData;
	assign regRdData = mem[regAddr[5:0]];
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic iicWr(input logic [6:0] dev, input logic [7:0] ra, d, input int n,
		input logic nak);
		logic a;
		i_mst.iStart();
		i_mst.iByte({dev, 1'b0}, 1'b1, x, a);
		chk("addr ack", {7'h00, nak}, {7'h00, a});
		for (int k = 0; k < n && !nak; k++)
		begin
			if (k == 0)
				i_mst.iByte(ra, 1'b1, x, a);
			i_mst.iByte(d + 8'(k), 1'b1, x, a);
			chk("data ack", 8'h00, {7'h00, a});
			shadow[ra + 8'(k)] = d + 8'(k);
		end
		i_mst.iStop();
	endtask
	task automatic iicRd(input logic [7:0] ra, input int n);
		logic a;
		i_mst.iStart();
		i_mst.iByte({DEV, 1'b0}, 1'b1, x, a);
		i_mst.iByte(ra, 1'b1, x, a);
		i_mst.iStart();
		i_mst.iByte({DEV, 1'b1}, 1'b1, x, a);
		chk("read ack", 8'h00, {7'h00, a});
		for (int k = 0; k < n; k++)
		begin
			i_mst.iByte(8'hff, k == n - 1, x, a);
			chk("iic data", shadow[ra + 8'(k)], x);
		end
		i_mst.iStop();
	endtask
	task automatic spiWr(input logic [5:0] ra, input logic [7:0] d, input int n);
		i_mst.sOpen();
		i_mst.sXfer({1'b1, ra, 1'b0}, 8, 1'b0, x);
		for (int k = 0; k < n; k++)
		begin
			i_mst.sXfer(d + 8'(k), 8, 1'b0, x);
			shadow[ra + 6'(k)] = d + 8'(k);
		end
		i_mst.sClose();
	endtask
	// Don't-care bit sent high on reads
	task automatic spiRd(input logic [5:0] ra, input int n);
		i_mst.sOpen();
		i_mst.sXfer({1'b0, ra, 1'b1}, 8, 1'b0, x);
		for (int k = 0; k < n; k++)
		begin
			i_mst.sXfer(8'hff, 8, spiThreeWire, x);
			chk("spi data", shadow[ra + 6'(k)], x);
		end
		i_mst.sClose();
	endtask
	task automatic summarize();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#3000000;
		fails++;
		summarize();
	end
	initial
	begin
		clock = 1'b0;
		rst_n = 1'b0;
		spiThreeWire = 1'b0;
		twoWireDisable = 1'b0;
		fails = 0;
		compares = 0;
		for (int i = 0; i < 64; i++)
		begin
			mem[i] = 8'(i) ^ 8'h5a;
			shadow[i] = 8'(i) ^ 8'h5a;
		end
		i_mst.w(6);
		rst_n = 1'b1;
		chk("regAddr", 8'h00, regAddr);
		chk("oe_n", 8'h01, {7'h00, serialInLineOe_n});
		i_mst.w(4);
		foreach (rows[i])
		begin
			spiThreeWire = rows[i].three;
			case (rows[i].kind)
				2'h0: iicWr(DEV, {2'h0, rows[i].ra}, rows[i].d, 1, 1'b0);
				2'h1: iicRd({2'h0, rows[i].ra}, 1);
				2'h2: spiWr(rows[i].ra, rows[i].d, 1);
				default: spiRd(rows[i].ra, 1);
			endcase
			chk("row", rows[i].d, mem[rows[i].ra]);
		end
		foreach (bad[i])
			iicWr(bad[i], 8'h05, 8'h77, 1, 1'b1);
		iicRd(8'h05, 1);
		iicWr(DEV, 8'h30, 8'hf0, 3, 1'b0);
		iicRd(8'h30, 3);
		spiWr(6'h38, 8'h0e, 2);
		spiThreeWire = 1'b1;
		spiRd(6'h38, 2);
		spiThreeWire = 1'b0;
		i_mst.sOpen();
		i_mst.sXfer(8'hff, 4, 1'b0, x);
		i_mst.sClose();
		spiWr(6'h11, 8'h42, 1);
		spiRd(6'h11, 1);
		twoWireDisable = 1'b1;
		iicWr(DEV, 8'h06, 8'h99, 1, 1'b1);
		twoWireDisable = 1'b0;
		iicRd(8'h06, 1);
		summarize();
	end
endmodule
